// ---- rtl/cbn_pkg.sv ----
`default_nettype none
package cbn_pkg;
   // clock rate and indicator / detection timing
   localparam int CLK_HZ      = 10_000_000;
   localparam int FLICKER_MS  = 50;
   localparam int DWELL_MS    = 100;
   localparam int FLICKER_CYC = CLK_HZ / 1000 * FLICKER_MS;
   localparam int DWELL_CYC   = CLK_HZ / 1000 * DWELL_MS;
   localparam logic [3:0] FLASH_TICKS = 4'h5;

   // bit-rate codes
   localparam logic [3:0] RATE_AUTO    = 4'h0;
   localparam logic [3:0] RATE_MIN     = 4'h1;
   localparam logic [3:0] RATE_MAX     = 4'h8;
   localparam logic [3:0] RATE_DEFAULT = 4'h6;

   // node id range
   localparam logic [6:0] NODE_MIN = 7'h01;
   localparam logic [6:0] NODE_MAX = 7'h7E;

   // display code shown for a bad address, value is arbitrary
   localparam logic [7:0] ADDR_ERR_CODE = 8'h01;

   // register byte addresses
   localparam logic [7:0] ADDR_MASK    = 8'hFC;
   localparam logic [7:0] REG_STATUS   = 8'h00;
   localparam logic [7:0] REG_CONFIG   = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // interrupt bits
   localparam int IRQ_W     = 4;
   localparam int IRQ_FOUND = 0;
   localparam int IRQ_BOOT  = 1;
   localparam int IRQ_ADDR  = 2;
   localparam int IRQ_INIT  = 3;

   // settings from the parameter store
   typedef struct packed {
      logic       reset_flag;
      logic [1:0] unit;
      logic [3:0] rate_code;
      logic [6:0] node_id;
   } cbn_cfg_type;

   // scaling units of the three exchanged objects
   typedef struct packed {
      logic [1:0] speed_cmd;
      logic [1:0] out_freq;
      logic [1:0] motor_speed;
   } cbn_units_type;

   // control toward the can core
   typedef struct packed {
      logic [3:0] rate_code;
      logic [9:0] rate_kbps;
      logic       listen_only;
      logic       tx_enable;
      logic       ack_enable;
   } cbn_can_ctrl_type;

   // status word layout
   typedef struct packed {
      logic [6:0] pad;
      logic [9:0] rate_kbps;
      logic [6:0] node_id;
      logic       preop;
      logic       node_valid;
      logic       detecting;
      logic       auto_mode;
      logic [3:0] rate_code;
   } cbn_status_type;

   // code to rate in kbps, zero for unused codes
   function automatic logic [9:0] rate_kbps(input logic [3:0] code);
      unique case (code)
         4'h1:    rate_kbps = 10'h00A;
         4'h2:    rate_kbps = 10'h014;
         4'h3:    rate_kbps = 10'h032;
         4'h4:    rate_kbps = 10'h07D;
         4'h5:    rate_kbps = 10'h0FA;
         4'h6:    rate_kbps = 10'h1F4;
         4'h7:    rate_kbps = 10'h320;
         4'h8:    rate_kbps = 10'h3E8;
         default: rate_kbps = 10'h000;
      endcase
   endfunction
endpackage
`default_nettype wire

// ---- rtl/cbn_setup.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbn_setup
   import cbn_pkg::*;
#(
   parameter int FLICKER_CYC_P = cbn_pkg::FLICKER_CYC,
   parameter int DWELL_CYC_P   = cbn_pkg::DWELL_CYC
) (
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // axi4-lite slave
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output var  logic                      s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output var  logic                      s_axi_wready,
   output var  logic [1:0]                s_axi_bresp,
   output var  logic                      s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output var  logic                      s_axi_arready,
   output var  logic [31:0]               s_axi_rdata,
   output var  logic [1:0]                s_axi_rresp,
   output var  logic                      s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // parameter store
   input  wire cbn_pkg::cbn_cfg_type      param_in,
   input  wire logic                      drive_init_pulse,
   // can core
   input  wire logic                      rx_frame_ok,
   input  wire logic                      rx_frame_err,
   output var  cbn_pkg::cbn_can_ctrl_type can_ctrl,
   output var  logic                      boot_req,
   output var  logic [6:0]                boot_node_id,
   // indicators and drive side
   output var  logic                      led_run,
   output var  logic                      led_err,
   output var  logic                      disp_addr_err,
   output var  logic [7:0]                disp_code,
   output var  logic                      comm_defaults_restore,
   output var  cbn_pkg::cbn_units_type    unit_scale,
   output var  logic                      irq
);
   import cbn_pkg::*;

   typedef enum logic [2:0] {PH_CAPTURE, PH_DETECT, PH_BOOT, PH_PREOP, PH_HALT} cbn_phase_type;

   typedef struct packed {
      cbn_phase_type    phase;
      cbn_cfg_type      cfg;
      logic [3:0]       cand;
      logic [3:0]       rate;
      logic [23:0]      dwell;
      logic [23:0]      tick_cnt;
      logic [3:0]       flash_cnt;
      logic             flick;
      logic             flash;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic             aw_held;
      logic [7:0]       aw_addr;
      logic             w_held;
      logic [7:0]       w_data;
      logic             w_lane0;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      cbn_can_ctrl_type can;
      logic             boot_req;
      logic [6:0]       boot_node;
      logic             led_run;
      logic             led_err;
      logic             disp_err;
      logic [7:0]       disp_code;
      logic             restore;
      cbn_units_type    units;
      logic             irq;
   } cbn_state_type;

   cbn_state_type q;
   cbn_state_type n;

   // next-state logic for the whole block
   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      logic             tick;
      logic             node_ok;
      cbn_status_type   sw;
      ev      = '0;
      clr     = '0;
      sw      = '0;
      tick    = 1'b0;
      node_ok = 1'b0;
      n       = q;
      n.boot_req = 1'b0;
      n.restore  = 1'b0;
      node_ok = (q.cfg.node_id >= NODE_MIN) && (q.cfg.node_id <= NODE_MAX);

      // indicator divider, one enable per flicker period
      tick = (q.tick_cnt == 24'(FLICKER_CYC_P - 1));
      n.tick_cnt = tick ? '0 : q.tick_cnt + 24'h1;
      if (tick) begin
         n.flick = ~q.flick;
         if (q.flash_cnt == FLASH_TICKS - 4'h1) begin
            n.flash_cnt = '0;
            n.flash     = ~q.flash;
         end else begin
            n.flash_cnt = q.flash_cnt + 4'h1;
         end
      end

      // start-up sequence
      unique case (q.phase)
         PH_CAPTURE: begin
            n.cfg = param_in;
            if (param_in.rate_code == RATE_AUTO) begin
               n.phase = PH_DETECT;
               n.cand  = RATE_MIN;
               n.dwell = '0;
            end else begin
               if (param_in.rate_code > RATE_MAX) begin
                  n.rate = RATE_DEFAULT;
               end else begin
                  n.rate = param_in.rate_code;
               end
               n.phase = PH_BOOT;
            end
         end
         PH_DETECT: begin
            if (rx_frame_ok) begin
               n.rate          = q.cand;
               ev[IRQ_FOUND]   = 1'b1;
               n.phase         = PH_BOOT;
            end else if (rx_frame_err || (q.dwell == 24'(DWELL_CYC_P - 1))) begin
               n.cand  = (q.cand == RATE_MAX) ? RATE_MIN : q.cand + 4'h1;
               n.dwell = '0;
            end else begin
               n.dwell = q.dwell + 24'h1;
            end
         end
         PH_BOOT: begin
            if (node_ok) begin
               n.boot_req    = 1'b1;
               n.boot_node   = q.cfg.node_id;
               ev[IRQ_BOOT]  = 1'b1;
               n.phase       = PH_PREOP;
            end else begin
               ev[IRQ_ADDR]  = 1'b1;
               n.phase       = PH_HALT;
            end
         end
         PH_PREOP: n.phase = PH_PREOP;
         PH_HALT:  n.phase = PH_HALT;
         default:  n.phase = PH_CAPTURE;
      endcase

      // rate code and kbps to the can core
      n.can.rate_code = (n.phase == PH_DETECT) ? n.cand : n.rate;
      n.can.rate_kbps = rate_kbps(n.can.rate_code);
      n.can.listen_only = (n.phase != PH_PREOP);
      n.can.tx_enable   = (n.phase == PH_PREOP);
      n.can.ack_enable  = (n.phase == PH_PREOP);

      // indicators follow the phase being entered
      n.led_run   = 1'b0;
      n.led_err   = 1'b0;
      n.disp_err  = 1'b0;
      n.disp_code = '0;
      if (n.phase == PH_DETECT) begin
         n.led_run = n.flick;
         n.led_err = ~n.flick;
      end else if (n.phase == PH_HALT) begin
         n.led_err   = n.flash;
         n.disp_err  = 1'b1;
         n.disp_code = ADDR_ERR_CODE;
      end else if (n.phase == PH_PREOP) begin
         n.led_run = 1'b1;
      end

      if (drive_init_pulse && param_in.reset_flag) begin
         n.restore     = 1'b1;
         ev[IRQ_INIT]  = 1'b1;
      end

      n.units.speed_cmd   = param_in.unit;
      n.units.out_freq    = param_in.unit;
      n.units.motor_speed = param_in.unit;

      // write address and data, taken in either order
      if (q.awready && s_axi_awvalid) begin
         n.aw_held = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (q.wready && s_axi_wvalid) begin
         n.w_held  = 1'b1;
         n.w_data  = s_axi_wdata[7:0];
         n.w_lane0 = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      // write commit once both halves are held
      if (q.aw_held && q.w_held && !q.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = RESP_OKAY;
         unique case (q.aw_addr & ADDR_MASK)
            REG_STATUS, REG_CONFIG: n.bresp = RESP_OKAY;
            REG_IRQ_STAT: clr = q.w_lane0 ? q.w_data[IRQ_W-1:0] : '0;
            REG_IRQ_MASK: begin
               if (q.w_lane0) begin
                  n.irq_mask = q.w_data[IRQ_W-1:0];
               end
            end
            default: n.bresp = RESP_SLVERR;
         endcase
      end
      // sticky events, a set in the clearing cycle survives
      n.irq_stat = (q.irq_stat & ~clr) | ev;
      n.irq      = |(n.irq_stat & n.irq_mask);
      n.awready  = !n.aw_held && !n.bvalid;
      n.wready   = !n.w_held && !n.bvalid;

      // read channel, one outstanding read
      sw.rate_code  = q.can.rate_code;
      sw.auto_mode  = (q.cfg.rate_code == RATE_AUTO);
      sw.detecting  = (q.phase == PH_DETECT) || (q.phase == PH_CAPTURE);
      sw.node_valid = node_ok;
      sw.preop      = (q.phase == PH_PREOP);
      sw.node_id    = q.cfg.node_id;
      sw.rate_kbps  = q.can.rate_kbps;
      if (q.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (q.arready && s_axi_arvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         n.rdata  = '0;
         unique case (s_axi_araddr & ADDR_MASK)
            REG_STATUS:   n.rdata = sw;
            REG_CONFIG:   n.rdata = 32'(q.cfg);
            REG_IRQ_STAT: n.rdata = 32'(q.irq_stat);
            REG_IRQ_MASK: n.rdata = 32'(q.irq_mask);
            default:      n.rresp = RESP_SLVERR;
         endcase
      end
      n.arready = !n.rvalid;
   end

   // single state register, synchronous reset to all zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready         = q.awready;
   assign s_axi_wready          = q.wready;
   assign s_axi_bresp           = q.bresp;
   assign s_axi_bvalid          = q.bvalid;
   assign s_axi_arready         = q.arready;
   assign s_axi_rdata           = q.rdata;
   assign s_axi_rresp           = q.rresp;
   assign s_axi_rvalid          = q.rvalid;
   assign can_ctrl              = q.can;
   assign boot_req              = q.boot_req;
   assign boot_node_id          = q.boot_node;
   assign led_run               = q.led_run;
   assign led_err               = q.led_err;
   assign disp_addr_err         = q.disp_err;
   assign disp_code             = q.disp_code;
   assign comm_defaults_restore = q.restore;
   assign unit_scale            = q.units;
   assign irq                   = q.irq;
endmodule // cbn_setup
`default_nettype wire

// ---- test/cbn_setup_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbn_setup_chk (
   // clock and reset
   input wire logic                      aclk,
   input wire logic                      aresetn,
   // drive and bus side inputs
   input wire cbn_pkg::cbn_cfg_type      param_in,
   input wire logic                      drive_init_pulse,
   input wire logic                      rx_frame_ok,
   // observed outputs
   input wire cbn_pkg::cbn_can_ctrl_type can_ctrl,
   input wire logic                      boot_req,
   input wire logic [6:0]                boot_node_id,
   input wire logic                      led_run,
   input wire logic                      led_err,
   input wire logic                      disp_addr_err,
   input wire logic [7:0]                disp_code,
   input wire logic                      comm_defaults_restore,
   input wire cbn_pkg::cbn_units_type    unit_scale
);
   import cbn_pkg::*;
   logic [1:0] boot_cnt_r;
   logic [9:0] kbps_exp;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // boot-ups since reset, saturating so a repeat stays visible
   always_ff @(posedge aclk) begin
      if (!aresetn) boot_cnt_r <= 2'h0;
      else if (boot_req && boot_cnt_r != 2'h3) boot_cnt_r <= boot_cnt_r + 2'h1;
   end
   // own rate table, kept apart from the design's lookup
   always_comb begin
      case (can_ctrl.rate_code)
         4'h1: kbps_exp = 10'h00A;
         4'h2: kbps_exp = 10'h014;
         4'h3: kbps_exp = 10'h032;
         4'h4: kbps_exp = 10'h07D;
         4'h5: kbps_exp = 10'h0FA;
         4'h6: kbps_exp = 10'h1F4;
         4'h7: kbps_exp = 10'h320;
         4'h8: kbps_exp = 10'h3E8;
         default: kbps_exp = 10'h3FF;
      endcase
   end
   chk_quiet_detect: assert property (
      can_ctrl.listen_only |-> !can_ctrl.tx_enable && !can_ctrl.ack_enable && !boot_req)
      else $error("transmit while detecting");
   // equal indicators while listening without an address error are only legal in the
   // one-cycle boot step after a rate is found or fixed, so next cycle the node must leave listening or show the address error
   chk_led_flicker: assert property (
      can_ctrl.listen_only && !disp_addr_err && led_run == led_err |=> !can_ctrl.listen_only || disp_addr_err)
      else $error("indicators not alternating");
   chk_rate_table: assert property (
      can_ctrl.tx_enable |-> can_ctrl.rate_kbps == kbps_exp) else $error("rate code and kbps disagree");
   chk_rate_held: assert property (
      can_ctrl.tx_enable && $past(can_ctrl.tx_enable) |-> $stable(can_ctrl.rate_code) && $stable(boot_node_id))
      else $error("setting changed while running");
   chk_boot_once: assert property (
      boot_req |-> boot_cnt_r == 2'h0) else $error("second boot-up");
   chk_boot_preop: assert property (
      boot_req |-> can_ctrl.tx_enable && !can_ctrl.listen_only && boot_node_id >= NODE_MIN
         && boot_node_id <= NODE_MAX) else $error("bad boot-up");
   chk_found_boot: assert property (
      rx_frame_ok && can_ctrl.listen_only |-> ##[1:4] (boot_req || disp_addr_err))
      else $error("good frame not accepted");
   chk_addr_err: assert property (
      disp_addr_err |-> disp_code == ADDR_ERR_CODE && !can_ctrl.tx_enable) else $error("address error output");
   chk_restore_src: assert property (
      $past(aresetn) |-> comm_defaults_restore == ($past(drive_init_pulse) && $past(param_in.reset_flag)))
      else $error("restore pulse wrong");
   chk_units_follow: assert property (
      $past(aresetn) |-> unit_scale == {3{$past(param_in.unit)}}) else $error("units not following");
endmodule // cbn_setup_chk
bind cbn_setup cbn_setup_chk cbn_setup_chk_i (.aclk, .aresetn, .param_in, .drive_init_pulse, .rx_frame_ok,
   .can_ctrl, .boot_req, .boot_node_id, .led_run, .led_err, .disp_addr_err, .disp_code,
   .comm_defaults_restore, .unit_scale);
`default_nettype wire

// ---- test/cbn_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cbn_bus_model (
   // clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // network setup chosen by the bench
   input  wire logic                      traffic_on,
   input  wire logic [3:0]                net_rate,
   // node under test
   input  wire cbn_pkg::cbn_can_ctrl_type can_ctrl,
   output var  logic                      rx_frame_ok,
   output var  logic                      rx_frame_err
);
   logic [2:0] gap_r;
   // a peer at net_rate sends a frame every eight cycles; a receiver
   // tuned elsewhere only sees garbage, and with no traffic sees nothing
   // peer traffic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= 3'h0;
         rx_frame_ok <= 1'h0;
         rx_frame_err <= 1'h0;
      end else begin
         gap_r <= gap_r + 3'h1;
         rx_frame_ok <= traffic_on && gap_r == 3'h7 && can_ctrl.rate_code == net_rate;
         rx_frame_err <= traffic_on && gap_r == 3'h7 && can_ctrl.rate_code != net_rate;
      end
   end
endmodule // cbn_bus_model
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cbn_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, drive_init_pulse, rx_frame_ok, rx_frame_err;
   logic boot_req, led_run, led_err, disp_addr_err, comm_defaults_restore, irq, traffic_on;
   logic [7:0] s_axi_awaddr, s_axi_araddr, disp_code;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, net_rate;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [6:0] boot_node_id;
   cbn_cfg_type param_in;
   cbn_can_ctrl_type can_ctrl;
   cbn_units_type unit_scale;
   int err_count, checks_done;
   // short counts keep indicator and dwell timing inside a quick run
   cbn_setup #(.FLICKER_CYC_P(4), .DWELL_CYC_P(20)) cbn_setup_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .param_in, .drive_init_pulse, .rx_frame_ok, .rx_frame_err, .can_ctrl, .boot_req,
      .boot_node_id, .led_run, .led_err, .disp_addr_err, .disp_code, .comm_defaults_restore, .unit_scale, .irq);
   cbn_bus_model cbn_bus_model_i (.aclk, .aresetn, .traffic_on, .net_rate, .can_ctrl, .rx_frame_ok, .rx_frame_err);
   // 10 MHz clock
   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [9:0] exp_kbps(input logic [3:0] c);
      logic [9:0] t [9] = '{10'h000, 10'h00A, 10'h014, 10'h032, 10'h07D, 10'h0FA, 10'h1F4, 10'h320, 10'h3E8};
      return t[c];
   endfunction
   // power cycle: a new rate code and node id are only taken here
   task automatic pwr_up(input cbn_cfg_type c);
      @(posedge aclk);
      aresetn <= 1'h0;
      param_in <= c;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
   endtask
   task automatic wait_boot(output logic seen);
      seen = 1'h0;
      for (int i = 0; i < 1500 && !seen; i++) begin
         @(negedge aclk);
         seen = (boot_req === 1'h1);
      end
   endtask
   // bready is raised with the request; it is legal and saves a cycle
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic done;
      done = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) begin
            rs = s_axi_bresp;
            s_axi_bready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      logic done;
      done = 1'h0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) begin
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            s_axi_rready <= 1'h0;
            done = 1'h1;
         end
      end
   endtask
   // every fixed code, code 9 falling back, node ids at both ends
   task automatic t_manual;
      logic s;
      logic [6:0] n;
      for (int c = 1; c <= 9; c++) begin
         n = (c == 8) ? 7'h7E : 7'(c);
         pwr_up({1'h0, 2'h0, 4'(c), n});
         wait_boot(s);
         chk(s, 1);
         chk(can_ctrl.rate_kbps, exp_kbps(c > 8 ? 4'h6 : 4'(c)));
         chk(boot_node_id, n);
         chk({can_ctrl.listen_only, can_ctrl.tx_enable, can_ctrl.ack_enable}, 3'h3);
         @(posedge aclk);
         param_in.rate_code <= 4'h3;
         param_in.node_id <= 7'h09;
         repeat (3) @(negedge aclk);
         chk({can_ctrl.rate_kbps, boot_node_id}, {exp_kbps(c > 8 ? 4'h6 : 4'(c)), n});
      end
   endtask
   // silent bus first, then traffic at rate r
   task automatic t_auto(input logic [3:0] r);
      logic s;
      int ones;
      ones = 0;
      traffic_on <= 1'h0;
      net_rate <= r;
      pwr_up({1'h0, 2'h0, 4'h0, 7'h2A});
      for (int i = 0; i < 100; i++) begin
         @(negedge aclk);
         if (i > 2) chk({can_ctrl.listen_only, can_ctrl.tx_enable, can_ctrl.ack_enable, boot_req}, 4'h8);
         if (i > 2) chk(led_run ^ led_err, 1);
         ones += (led_run === 1'h1);
      end
      chk(ones > 30 && ones < 70, 1);
      @(posedge aclk);
      traffic_on <= 1'h1;
      wait_boot(s);
      chk(s, 1);
      chk({can_ctrl.rate_code, boot_node_id}, {r, 7'h2A});
      axi_rd(REG_STATUS);
      chk(rd, {7'h0, exp_kbps(r), 7'h2A, 4'hD, r});
   endtask
   // sticky status, mask, clear and an unmapped place
   task automatic t_irq;
      axi_rd(REG_IRQ_STAT);
      chk(rd, 32'h3);
      @(negedge aclk);
      chk(irq, 0);
      axi_wr(REG_IRQ_MASK, 32'h1);
      @(negedge aclk);
      chk({rs, irq}, {RESP_OKAY, 1'h1});
      axi_wr(REG_IRQ_STAT, 32'h1);
      @(negedge aclk);
      chk(irq, 0);
      axi_rd(REG_IRQ_STAT);
      chk(rd, 32'h2);
      // captured settings cannot be overwritten from the bus while running
      axi_wr(REG_CONFIG, 32'h0000_3FFF);
      chk(rs, RESP_OKAY);
      axi_rd(REG_CONFIG);
      chk(rd, 32'h0000_002A);
      axi_rd(8'h10);
      chk(rs, RESP_SLVERR);
      chk(rd, 32'h0);
      axi_wr(8'h10, 32'hF);
      chk(rs, RESP_SLVERR);
   endtask
   // address zero, then drive initialization with either flag, then units
   task automatic t_addr_init;
      int tg;
      logic b, p;
      tg = 0;
      b = 1'h0;
      p = 1'h0;
      pwr_up({1'h0, 2'h0, 4'h6, 7'h00});
      for (int i = 0; i < 60; i++) begin
         @(negedge aclk);
         b |= (boot_req === 1'h1);
         tg += (led_err !== p);
         p = led_err;
      end
      chk({b, disp_addr_err, disp_code, can_ctrl.tx_enable}, {2'h1, 8'h01, 1'h0});
      chk(tg >= 2 && tg <= 4, 1);
      for (int f = 1; f >= 0; f--) begin
         @(posedge aclk);
         param_in.reset_flag <= 1'(f);
         drive_init_pulse <= 1'h1;
         @(posedge aclk);
         drive_init_pulse <= 1'h0;
         @(negedge aclk);
         chk(comm_defaults_restore, f);
         @(negedge aclk);
         chk(comm_defaults_restore, 0);
      end
      axi_rd(REG_IRQ_STAT);
      chk(rd, 32'hC);
      @(posedge aclk);
      param_in.unit <= 2'h2;
      repeat (2) @(negedge aclk);
      chk(unit_scale, 6'h2A);
   endtask
   // cut a hang short
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      finish_test;
   end
   // main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {drive_init_pulse, traffic_on, net_rate, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      param_in = '0;
      err_count = 0;
      checks_done = 0;
      t_manual;
      t_auto(4'h7);
      t_irq;
      t_auto(4'h2);
      t_addr_init;
      finish_test;
   end
endmodule // testbench
`default_nettype wire
